// ### pad_decoder.sv
// Functional notes
// - High-speed area is a 2 MB window of 128 independent slots.
// - Low-speed area is a 1 MB window of 64 independent slots.
// - Each slot spans 16 kB; upper bits select, lower bits are offset.
// - Ethernet, DMA, hole and USB at first four high-speed slots.
// - High-speed slots 4 to 127 reserved; area ends at 0x5020_0000.
// - Low-speed slot at 0x4002_4000 reaches the real-time clock.
// - Vector area accesses can be redirected to another memory.
`timescale 1ns/10ps
`default_nettype none
`include "pad_params.svh"
module pad_decoder
  import pad_pkg::*;
#(
  parameter int HS_SLOTS = `PAD_HS_SLOTS,
  parameter int LS_SLOTS = `PAD_LS_SLOTS
)(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire pad_req_t               req,
  input  wire pad_vec_t               vec_map,
  output logic [HS_SLOTS-1:0]         hs_sel,
  output logic [LS_SLOTS-1:0]         ls_sel,
  output logic                        eth_sel,
  output logic                        general_dma_controller_sel,
  output logic                        usb_sel,
  output logic                        rtc_sel,
  output logic [`PAD_SLOT_BITS-1:0]   offset,
  output logic [31:0]                 vec_addr,
  output pad_vec_t                    vec_target,
  output logic                        vec_hit,
  output logic                        err
);
  if (HS_SLOTS != `PAD_HS_SLOTS || LS_SLOTS != `PAD_LS_SLOTS) begin : g_bad_slots
    $error("Slot counts fixed by window size");
  end

  pad_sel_t sel;
  pad_slot_decode u_dec (
    .addr (req.addr),
    .sel  (sel)
  );

  logic [HS_SLOTS-1:0]       hs_r, hs_nxt;
  logic [LS_SLOTS-1:0]       ls_r, ls_nxt;
  logic [`PAD_SLOT_BITS-1:0] off_r, off_nxt;
  logic [31:0]               va_r, va_nxt;
  pad_vec_t                  vt_r, vt_nxt;
  logic                      vh_r, vh_nxt;
  logic                      err_r, err_nxt;
  logic                      in_vec;

  assign in_vec = (req.addr >> `PAD_VEC_SIZE_BITS) == (`PAD_VEC_BASE >> `PAD_VEC_SIZE_BITS);

  always_comb begin
    hs_nxt  = '0;
    ls_nxt  = '0;
    off_nxt = req.addr[`PAD_SLOT_BITS-1:0];
    va_nxt  = req.addr;
    vt_nxt  = PAD_VEC_BOOT;
    vh_nxt  = 1'b0;
    err_nxt = 1'b0;
    if (req.valid) begin
      if (sel.hs_hit && !sel.err)
        hs_nxt[sel.slot] = 1'b1;
      if (sel.ls_hit)
        ls_nxt[sel.slot[5:0]] = 1'b1;
      err_nxt = sel.err;
      if (in_vec) begin
        vh_nxt = 1'b1;
        vt_nxt = vec_map;
        va_nxt = {{(32-`PAD_VEC_SIZE_BITS){1'b0}}, req.addr[`PAD_VEC_SIZE_BITS-1:0]};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_r  <= '0;
      ls_r  <= '0;
      off_r <= '0;
      va_r  <= '0;
      vt_r  <= PAD_VEC_BOOT;
      vh_r  <= 1'b0;
      err_r <= 1'b0;
    end else if (ce) begin
      hs_r  <= hs_nxt;
      ls_r  <= ls_nxt;
      off_r <= off_nxt;
      va_r  <= va_nxt;
      vt_r  <= vt_nxt;
      vh_r  <= vh_nxt;
      err_r <= err_nxt;
    end
  end

  assign hs_sel                     = hs_r;
  assign ls_sel                     = ls_r;
  assign eth_sel                    = hs_r[`PAD_HS_ETH_SLOT];
  assign general_dma_controller_sel = hs_r[`PAD_HS_DMA_SLOT];
  assign usb_sel                    = hs_r[`PAD_HS_USB_SLOT];
  assign rtc_sel                    = ls_r[`PAD_LS_RTC_SLOT];
  assign offset                     = off_r;
  assign vec_addr                   = va_r;
  assign vec_target                 = vt_r;
  assign vec_hit                    = vh_r;
  assign err                        = err_r;

  property p_onehot_hs;
    @(posedge clk) disable iff (rst) $onehot0(hs_sel);
  endproperty
  a_onehot_hs: assert property (p_onehot_hs) else $error("Two high-speed slots");

  property p_onehot_ls;
    @(posedge clk) disable iff (rst) $onehot0(ls_sel);
  endproperty
  a_onehot_ls: assert property (p_onehot_ls) else $error("Two low-speed slots");

  property p_offset;
    @(posedge clk) disable iff (rst) ce && req.valid |=> offset == $past(req.addr[13:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("Offset wrong");

  property p_dma;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:14] == 18'h1_4001 |=> general_dma_controller_sel;
  endproperty
  a_dma: assert property (p_dma) else $error("DMA not selected");

  property p_hole;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:14] == 18'h1_4002 |=> err && hs_sel == '0;
  endproperty
  a_hole: assert property (p_hole) else $error("Hole selected");

  property p_rsv;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr >= 32'h5001_0000 && req.addr < 32'h5020_0000 |=> err;
  endproperty
  a_rsv: assert property (p_rsv) else $error("Reserved slot without error");

  property p_rtc;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:14] == 18'h1_0009 |=> rtc_sel && !err;
  endproperty
  a_rtc: assert property (p_rtc) else $error("Clock slot missed");

  property p_vec;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr < 32'h0000_0200 |=> vec_hit && vec_target == $past(vec_map);
  endproperty
  a_vec: assert property (p_vec) else $error("Vector remap wrong");

  property p_err_nosel;
    @(posedge clk) disable iff (rst) err |-> hs_sel == '0 && ls_sel == '0;
  endproperty
  a_err_nosel: assert property (p_err_nosel) else $error("Error with selection");

  // Slot, window, idle, hold and vector checks
  property p_hs_slot;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:21] == 11'h280 &&
      (req.addr[20:14] < 7'h02 || req.addr[20:14] == 7'h03) |=>
      hs_sel == (128'h1 << $past(req.addr[20:14])) && !err;
  endproperty
  a_hs_slot: assert property (p_hs_slot) else $error("High-speed slot wrong");

  property p_eth;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:14] == 18'h1_4000 |=>
      eth_sel && !err;
  endproperty
  a_eth: assert property (p_eth) else $error("Ethernet not selected");

  property p_usb;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:14] == 18'h1_4003 |=>
      usb_sel && !err;
  endproperty
  a_usb: assert property (p_usb) else $error("USB not selected");

  property p_ls_slot;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr[31:20] == 12'h400 |=>
      ls_sel == (64'h1 << $past(req.addr[19:14])) && !err;
  endproperty
  a_ls_slot: assert property (p_ls_slot) else $error("Low-speed slot wrong");

  property p_outside;
    @(posedge clk) disable iff (rst)
      ce && req.valid && !(req.addr >= `PAD_HS_BASE && req.addr < `PAD_HS_END) &&
      !(req.addr >= `PAD_LS_BASE && req.addr < `PAD_LS_END) |=>
      hs_sel == '0 && ls_sel == '0 && !err;
  endproperty
  a_outside: assert property (p_outside) else $error("Selection outside areas");

  property p_idle;
    @(posedge clk) disable iff (rst)
      ce && !req.valid |=>
      hs_sel == '0 && ls_sel == '0 && !err && !vec_hit;
  endproperty
  a_idle: assert property (p_idle) else $error("Selection without access");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      !ce |=>
      $stable(hs_sel) && $stable(ls_sel) && $stable(offset) && $stable(vec_addr) &&
      $stable(vec_target) && $stable(vec_hit) && $stable(err);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Outputs moved while disabled");

  property p_vec_addr;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr < 32'h0000_0200 |=>
      vec_addr == {23'h0, $past(req.addr[8:0])};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("Vector offset wrong");

  property p_no_vec;
    @(posedge clk) disable iff (rst)
      ce && req.valid && req.addr >= 32'h0000_0200 |=>
      !vec_hit && vec_addr == $past(req.addr);
  endproperty
  a_no_vec: assert property (p_no_vec) else $error("Remap outside vector area");
endmodule // pad_decoder
`default_nettype wire

// ### pad_master.sv
`timescale 1ns/10ps
`default_nettype none
module pad_master
  import pad_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic        go,
  output var  pad_req_t    req
);
  // Idle bus shows inverted address, never a stale one
  assign req = '{valid: go, write: addr[0], addr: go ? addr : ~addr};
endmodule // pad_master
`default_nettype wire

// ### pad_params.svh
`ifndef PAD_PARAMS_SVH
`define PAD_PARAMS_SVH
`define PAD_HS_BASE       32'h5000_0000
`define PAD_HS_END        32'h5020_0000
`define PAD_HS_SLOTS      128
`define PAD_LS_BASE       32'h4000_0000
`define PAD_LS_END        32'h4010_0000
`define PAD_LS_SLOTS      64
`define PAD_SLOT_BITS     14
`define PAD_HS_ETH_SLOT   7'h00
`define PAD_HS_DMA_SLOT   7'h01
`define PAD_HS_RSV_SLOT   7'h02
`define PAD_HS_USB_SLOT   7'h03
`define PAD_HS_FIRST_RSV  7'h04
`define PAD_LS_RTC_SLOT   6'h09
`define PAD_VEC_BASE      32'h0000_0000
`define PAD_VEC_SIZE_BITS 9
`endif

// ### pad_pkg.sv
`default_nettype none
package pad_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
  } pad_req_t;
  typedef struct packed {
    logic        hs_hit;
    logic        ls_hit;
    logic [6:0]  slot;
    logic        err;
  } pad_sel_t;
  typedef enum logic [1:0] {PAD_VEC_BOOT, PAD_VEC_RAM, PAD_VEC_FLASH} pad_vec_t;
endpackage
`default_nettype wire

// ### pad_slot_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "pad_params.svh"
module pad_slot_decode
  import pad_pkg::*;
(
  input  wire logic [31:0] addr,
  output pad_sel_t         sel
);
  always_comb begin
    sel = '0;
    if (addr >= `PAD_HS_BASE && addr < `PAD_HS_END) begin
      sel.hs_hit = 1'b1;
      sel.slot   = addr[20:14];
      sel.err    = (addr[20:14] == `PAD_HS_RSV_SLOT) ||
                   (addr[20:14] >= `PAD_HS_FIRST_RSV);
    end else if (addr >= `PAD_LS_BASE && addr < `PAD_LS_END) begin
      sel.ls_hit = 1'b1;
      sel.slot   = {1'b0, addr[19:14]};
    end
  end
endmodule // pad_slot_decode
`default_nettype wire

// ### tb_pad_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pad_decoder
  import pad_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b0, go = 1'b0, eth, dma, usb, rtc, vh, er;
  logic [31:0] a = 32'h0000_0000, s = 32'hccaa_2d15, d, va;
  logic [127:0] hs;
  logic [63:0] ls;
  logic [13:0] off;
  logic [243:0] ev = '0;
  pad_req_t req;
  pad_vec_t vm = PAD_VEC_BOOT, vt, evt = PAD_VEC_BOOT;
  int err_count = 0, n_checks = 0;
  logic [31:0] cor [12] = '{32'h5000_0000, 32'h5000_4010, 32'h5000_8000, 32'h5000_C000,
    32'h5001_0000, 32'h501F_FFFF, 32'h5020_0000, 32'h4002_4000, 32'h400F_C000,
    32'h4010_0000, 32'h0000_01FF, 32'h0000_0200};
  wire logic [243:0] seen = {hs, ls, eth, dma, usb, rtc, off, va, vh, er};
  always #2 clk = ~clk;
  pad_master pad_master_inst (.addr(a), .go(go), .req(req));
  pad_decoder pad_decoder_inst (.clk(clk), .rst(rst), .ce(ce), .req(req), .vec_map(vm),
    .hs_sel(hs), .ls_sel(ls), .eth_sel(eth), .general_dma_controller_sel(dma),
    .usb_sel(usb), .rtc_sel(rtc), .offset(off), .vec_addr(va), .vec_target(vt),
    .vec_hit(vh), .err(er));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Idle master shows the inverted address; offset and vec_addr follow it
  function automatic logic [243:0] expv(input logic [31:0] x, input logic vld);
    logic h, e, v;
    logic [127:0] eh;
    logic [63:0] el;
    logic [31:0] b;
    b = vld ? x : ~x;
    h = vld && x[31:21] == 11'h280;
    e = h && (x[20:14] == 7'h02 || x[20:14] > 7'h03);
    eh = (h && !e) ? 128'h1 << x[20:14] : '0;
    el = (vld && x[31:20] == 12'h400) ? 64'h1 << x[19:14] : '0;
    v = vld && x[31:9] == '0;
    return {eh, el, eh[0], eh[1], eh[3], el[9], b[13:0], v ? {23'h0, x[8:0]} : b, v, e};
  endfunction
  task automatic chk(input logic [243:0] g, input logic [243:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, g, e);
    end
  endtask
  // m[0] enable, m[1] valid
  task automatic acc(input logic [31:0] x, input logic [1:0] m);
    @(posedge clk);
    a <= x;
    ce <= m[0];
    go <= m[1];
    vm <= pad_vec_t'(s[9:8] == 2'h3 ? 2'h1 : s[9:8]);
    @(posedge clk);
    #1;
    if (m[0]) ev = expv(x, m[1]);
    if (m[0]) evt = ev[1] ? vm : PAD_VEC_BOOT;
    chk(seen, ev);
    chk({242'h0, vt}, {242'h0, evt});
  endtask
  task automatic close_out;
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    chk(seen, '0);
    chk({242'h0, vt}, {242'h0, PAD_VEC_BOOT});
    rst <= 1'b0;
    foreach (cor[i]) acc(cor[i], 2'h3);
    for (int i = 0; i < 400; i++) begin
      s = xs(s);
      case (s[1:0])
        2'h0: d = {11'h280, s[20:0]};
        2'h1: d = {12'h400, s[19:0]};
        2'h2: d = {23'h0, s[8:0]};
        default: d = s;
      endcase
      acc(d, {s[31:29] != 3'h0, s[28:26] != 3'h0});
    end
    close_out;
  end
endmodule // tb_pad_decoder
`default_nettype wire
